// ---- design/i2c_bridge_host_port.sv ----
// serial slave host port of the bridge: framing, command decode, register reads
// Overview of operation
// R1: triplet parameter uses only bit 7
// R2: works at 100 and 400 kbit/s
// R3: bytes MSB first, each followed by acknowledge
// R4: address last bit picks write or read
// R5: SDA fall with SCL high starts address
// R6: SDA rise with SCL high ends transfer
// R7: repeated START handled like plain START
// R8: SDA changes only while SCL low
// R9: received bits captured on SCL rise
// R10: transmit bit driven after SCL fall
// R11: host master makes every SCL pulse
// R12: acknowledge holds SDA low whole ninth pulse
// R13: refused byte leaves SDA released
// R14: host restarts after a refusal
// R15: host nack ends read, SDA released
// R16: write: code, parameter, ack only valid
// R17: read returns pointer register repeatedly
// R18: host sets pointer before reading another
// R19: control codes F0, E1, D2
// R20: port codes C3, B4, 87
// R21: byte codes A5, 96, 78
// R22: line commands refused while line busy
// R23: SCL is input only, never stretched
// R24: pins synchronised and filtered before decoding
// R25: device reset returns port to idle
`timescale 1ns/100ps
module i2c_bridge_host_port #(
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  // system clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // serial bus pins; scl also clocks the capture flop
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // command engine side
  input wire logic line_busy_flag,
  input wire logic [7:0] read_data,
  output logic cmd_valid,
  output bridge_host_pkg::cmd_t cmd,
  output logic dev_reset,
  output logic [7:0] read_ptr
);
  import bridge_host_pkg::*;

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  // the filter delay must stay well inside a fast-mode bit
  if (FAST_BIT_CYCLES < 4 * SYNC_DEPTH) begin : g_rate_chk // R2
    $error("system clock too slow for fast mode");
  end

  // ------------------------------------------------------------
  // command classification
  // ------------------------------------------------------------
  function automatic logic cmd_known(input logic [7:0] c);
    case (c)
      DEVICE_RESET_CMD, SET_POINTER_CMD, WRITE_CONFIG_CMD, // R19
      ADJUST_PORT_CMD, LINE_RESET_CMD, SINGLE_SLOT_CMD, // R20
      BYTE_WRITE_CMD, BYTE_READ_CMD, SEARCH_TRIPLET_CMD: cmd_known = 1'b1; // R21
      default: cmd_known = 1'b0;
    endcase
  endfunction : cmd_known

  function automatic logic cmd_has_param(input logic [7:0] c);
    case (c)
      SET_POINTER_CMD, WRITE_CONFIG_CMD, ADJUST_PORT_CMD, SINGLE_SLOT_CMD,
      BYTE_WRITE_CMD, SEARCH_TRIPLET_CMD: cmd_has_param = 1'b1;
      default: cmd_has_param = 1'b0;
    endcase
  endfunction : cmd_has_param

  // commands that touch the line or its setup are refused while the line is busy
  function automatic logic cmd_line_gated(input logic [7:0] c);
    cmd_line_gated = cmd_known(c) && c != DEVICE_RESET_CMD && c != SET_POINTER_CMD;
  endfunction : cmd_line_gated

  function automatic logic ptr_valid(input logic [7:0] p);
    ptr_valid = p == PTR_STATUS || p == PTR_DATA || p == PTR_PORT || p == PTR_DEVICE_CFG;
  endfunction : ptr_valid

  // ------------------------------------------------------------
  // link side: capture SDA on the SCL rise, flag it with a toggle
  // ------------------------------------------------------------
  link_t link_reg;
  link_t link_next;

  always_comb begin
    link_next.sda_cap = sda_i; // R9
    link_next.tog = ~link_reg.tog;
  end

  // scl is only ever an input here, so the port cannot stretch it
  always_ff @(posedge scl or negedge rst_b) begin // R23
    if (!rst_b) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  // ------------------------------------------------------------
  // system side state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0] scl_s, sda_s, tog_s;
    logic scl_f, sda_f, tog_seen;
    port_state_t state;
    byte_phase_t phase;
    logic [3:0] cnt;
    logic [7:0] shift, tx;
    logic dir, host_ack, reset_pend, oe;
    logic [7:0] code, ptr;
    logic cmd_valid;
    cmd_t cmd;
    logic dev_reset;
  } port_t;

  port_t r_reg;
  port_t r_next;
  logic scl_new, sda_new, tog_new;
  logic start_ev, stop_ev, rise_ev, fall_ev, rx_bit;

  // a level counts only once the second and third stages agree
  always_comb begin
    scl_new = (r_reg.scl_s[1] == r_reg.scl_s[2]) ? r_reg.scl_s[2] : r_reg.scl_f; // R24
    sda_new = (r_reg.sda_s[1] == r_reg.sda_s[2]) ? r_reg.sda_s[2] : r_reg.sda_f; // R24
    tog_new = (r_reg.tog_s[1] == r_reg.tog_s[2]) ? r_reg.tog_s[2] : r_reg.tog_seen;
    start_ev = r_reg.scl_f && scl_new && r_reg.sda_f && !sda_new; // R5
    stop_ev = r_reg.scl_f && scl_new && !r_reg.sda_f && sda_new; // R6
    fall_ev = r_reg.scl_f && !scl_new;
    rise_ev = tog_new != r_reg.tog_seen;
    // the capture flop is long settled by the time its toggle is seen
    rx_bit = link_reg.sda_cap;
  end

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.cmd_valid = 1'b0;
    r_next.dev_reset = 1'b0;
    r_next.scl_s = {r_reg.scl_s[1:0], scl};
    r_next.sda_s = {r_reg.sda_s[1:0], sda_i};
    r_next.tog_s = {r_reg.tog_s[1:0], link_reg.tog};
    r_next.scl_f = scl_new;
    r_next.sda_f = sda_new;
    r_next.tog_seen = tog_new;
    case (r_reg.state)
      ST_IDLE: begin
        r_next.oe = 1'b0;
      end
      ST_RX: begin
        if (rise_ev && r_reg.cnt != BYTE_DONE_CNT) begin
          r_next.shift = {r_reg.shift[6:0], rx_bit}; // R3
          r_next.cnt = r_reg.cnt + 4'h1;
        end
        // decide on the byte at the fall that closes its eighth bit
        if (fall_ev && r_reg.cnt == BYTE_DONE_CNT) begin
          r_next.state = ST_IGNORE; // R13
          r_next.oe = 1'b0;
          case (r_reg.phase)
            PH_ADDR: begin
              if (r_reg.shift[7:1] == DEV_ADDR) begin
                r_next.state = ST_ACK;
                r_next.dir = r_reg.shift[DIR_BIT]; // R4
                r_next.phase = PH_CMD;
              end
            end
            PH_CMD: begin
              // busy refusal drops the command; nothing reaches the engine
              if (cmd_known(r_reg.shift) &&
                  !(cmd_line_gated(r_reg.shift) && line_busy_flag)) begin // R16 R22
                r_next.state = ST_ACK;
                r_next.code = r_reg.shift;
                if (cmd_has_param(r_reg.shift)) begin
                  r_next.phase = PH_PARAM;
                end else begin
                  r_next.phase = PH_EXTRA;
                  r_next.cmd_valid = 1'b1;
                  r_next.cmd = '{code: r_reg.shift, param: 8'h00};
                  if (r_reg.shift == DEVICE_RESET_CMD) begin
                    r_next.reset_pend = 1'b1; // R25
                    r_next.dev_reset = 1'b1;
                    r_next.ptr = PTR_RESET;
                  end
                end
              end
            end
            PH_PARAM: begin
              if (r_reg.code == SET_POINTER_CMD) begin
                if (ptr_valid(r_reg.shift)) begin // R16
                  r_next.state = ST_ACK;
                  r_next.ptr = r_reg.shift;
                  r_next.phase = PH_EXTRA;
                end
              end else begin
                r_next.state = ST_ACK;
                r_next.cmd_valid = 1'b1;
                r_next.cmd = '{code: r_reg.code, param: r_reg.shift};
                if (r_reg.code == SEARCH_TRIPLET_CMD) begin
                  r_next.cmd.param = {r_reg.shift[TRIPLET_DIR_BIT], TRIPLET_IGNORED}; // R1
                end
                // port adjustment takes further control bytes
                r_next.phase = (r_reg.code == ADJUST_PORT_CMD) ? PH_PARAM : PH_EXTRA;
              end
            end
            default: begin
              r_next.state = ST_IGNORE; // R16
            end
          endcase
          if (r_next.state == ST_ACK) begin
            r_next.oe = 1'b1; // R12
          end
        end
      end
      ST_ACK: begin
        // hold SDA low until SCL falls after the ninth pulse
        if (fall_ev) begin // R12
          r_next.cnt = 4'h0;
          r_next.oe = 1'b0;
          if (r_reg.reset_pend) begin
            r_next.reset_pend = 1'b0;
            r_next.state = ST_IDLE; // R25
          end else if (r_reg.dir) begin
            r_next.tx = read_data; // R17
            r_next.oe = !read_data[BYTE_BITS-1]; // R10
            r_next.state = ST_TX;
          end else begin
            r_next.state = ST_RX;
          end
        end
      end
      ST_TX: begin
        if (rise_ev) begin
          r_next.cnt = r_reg.cnt + 4'h1;
        end
        if (fall_ev) begin
          if (r_reg.cnt == BYTE_DONE_CNT) begin
            r_next.oe = 1'b0;
            r_next.host_ack = 1'b0;
            r_next.state = ST_HACK;
          end else begin
            r_next.tx = {r_reg.tx[6:0], 1'b0};
            r_next.oe = !r_reg.tx[BYTE_BITS-2]; // R8 R10
          end
        end
      end
      ST_HACK: begin
        if (rise_ev) begin
          if (rx_bit) begin
            r_next.state = ST_IGNORE; // R15
          end else begin
            r_next.host_ack = 1'b1;
          end
        end
        // same register again, no readdressing needed
        if (fall_ev && r_reg.host_ack) begin
          r_next.cnt = 4'h0;
          r_next.tx = read_data; // R17
          r_next.oe = !read_data[BYTE_BITS-1]; // R10
          r_next.state = ST_TX;
        end
      end
      ST_IGNORE: begin
        r_next.oe = 1'b0;
      end
      default: begin
        r_next.state = ST_IDLE;
        r_next.oe = 1'b0;
      end
    endcase
    // a START anywhere, repeated or not, opens a new address byte
    if (start_ev) begin // R5 R7
      r_next.state = ST_RX;
      r_next.phase = PH_ADDR;
      r_next.cnt = 4'h0;
      r_next.oe = 1'b0;
      r_next.reset_pend = 1'b0;
    end else if (stop_ev) begin // R6
      r_next.state = ST_IDLE;
      r_next.oe = 1'b0;
      r_next.reset_pend = 1'b0;
    end
  end

  // state register; the synchroniser stages live here too
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      r_reg <= '{scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1, sda_f: 1'b1,
                 state: ST_IDLE, phase: PH_ADDR, ptr: PTR_RESET, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // open drain: the pin is only ever pulled low
  assign sda_o = 1'b0;
  assign sda_oe = r_reg.oe;
  assign cmd_valid = r_reg.cmd_valid;
  assign cmd = r_reg.cmd;
  assign dev_reset = r_reg.dev_reset;
  assign read_ptr = r_reg.ptr;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_byte_done;
    r_reg.state == ST_RX && fall_ev && r_reg.cnt == BYTE_DONE_CNT;
  endsequence
  sequence s_cmd_busy;
    s_byte_done ##0 (r_reg.phase == PH_CMD && line_busy_flag &&
                     cmd_line_gated(r_reg.shift));
  endsequence

  start_addr_a: assert property (start_ev |=> // R5
    r_reg.state == ST_RX && r_reg.phase == PH_ADDR && r_reg.cnt == 4'h0)
    else $error("start did not open an address byte");
  restart_a: assert property ((start_ev && r_reg.state != ST_IDLE) |=> // R7
    r_reg.state == ST_RX && !r_reg.oe)
    else $error("repeated start not handled");
  stop_idle_a: assert property (stop_ev |=> r_reg.state == ST_IDLE && !sda_oe) // R6
    else $error("stop did not return to idle");
  sda_change_a: assert property (($changed(sda_oe) && !$past(start_ev || stop_ev)) // R8
    |-> !r_reg.scl_f)
    else $error("sda changed while scl high");
  capture_bit_a: assert property ((r_reg.state == ST_RX && rise_ev && // R9
    r_reg.cnt != BYTE_DONE_CNT) |=> r_reg.shift[0] == $past(rx_bit))
    else $error("received bit not captured");
  ack_hold_a: assert property ((r_reg.state == ST_ACK && !fall_ev && !start_ev && // R12
    !stop_ev) |=> sda_oe)
    else $error("acknowledge released early");
  surplus_nack_a: assert property ((s_byte_done ##0 r_reg.phase == PH_EXTRA) // R13
    |=> !sda_oe ##1 !sda_oe)
    else $error("surplus byte acknowledged");
  busy_refuse_a: assert property (s_cmd_busy |=> // R22
    r_reg.state == ST_IGNORE && !sda_oe && !cmd_valid)
    else $error("line command taken while busy");
  triplet_mask_a: assert property ((cmd_valid && cmd.code == SEARCH_TRIPLET_CMD) // R1
    |-> cmd.param[6:0] == TRIPLET_IGNORED)
    else $error("triplet parameter not masked");
  host_nack_a: assert property ((r_reg.state == ST_HACK && rise_ev && rx_bit && // R15
    !start_ev && !stop_ev) |=> r_reg.state == ST_IGNORE ##1 !sda_oe)
    else $error("sda held after host nack");
  reset_idle_a: assert property ((r_reg.state == ST_ACK && r_reg.reset_pend && // R25
    fall_ev && !start_ev && !stop_ev) |=> r_reg.state == ST_IDLE)
    else $error("device reset left port busy");

endmodule : i2c_bridge_host_port

// ---- design/bridge_host_pkg.sv ----
// constants, command map and carrier types for the bridge host port
package bridge_host_pkg;

  // ------------------------------------------------------------
  // command codes and read pointer codes
  // ------------------------------------------------------------
  localparam logic [7:0] DEVICE_RESET_CMD = 8'hF0;
  localparam logic [7:0] SET_POINTER_CMD = 8'hE1;
  localparam logic [7:0] WRITE_CONFIG_CMD = 8'hD2;
  localparam logic [7:0] ADJUST_PORT_CMD = 8'hC3;
  localparam logic [7:0] LINE_RESET_CMD = 8'hB4;
  localparam logic [7:0] SINGLE_SLOT_CMD = 8'h87;
  localparam logic [7:0] BYTE_WRITE_CMD = 8'hA5;
  localparam logic [7:0] BYTE_READ_CMD = 8'h96;
  localparam logic [7:0] SEARCH_TRIPLET_CMD = 8'h78;
  localparam logic [7:0] PTR_STATUS = 8'hF0;
  localparam logic [7:0] PTR_DATA = 8'hE1;
  localparam logic [7:0] PTR_PORT = 8'hB4;
  localparam logic [7:0] PTR_DEVICE_CFG = 8'hC3;
  localparam logic [7:0] PTR_RESET = PTR_STATUS;

  // ------------------------------------------------------------
  // byte layout and timing
  // ------------------------------------------------------------
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] BYTE_DONE_CNT = 4'h8;
  localparam int DIR_BIT = 0;
  localparam int TRIPLET_DIR_BIT = 7;
  localparam logic [6:0] TRIPLET_IGNORED = 7'h00;
  localparam int STD_RATE_KBPS = 100;
  localparam int FAST_RATE_KBPS = 400;
  localparam int CLK_RATE_KHZ = 10000;
  localparam int FAST_BIT_CYCLES = CLK_RATE_KHZ / FAST_RATE_KBPS;
  localparam int STD_BIT_CYCLES = CLK_RATE_KHZ / STD_RATE_KBPS;
  localparam int SYNC_DEPTH = 3;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_RX = 6'h02, ST_ACK = 6'h04,
    ST_TX = 6'h08, ST_HACK = 6'h10, ST_IGNORE = 6'h20
  } port_state_t;

  typedef enum logic [3:0] {
    PH_ADDR = 4'h1, PH_CMD = 4'h2, PH_PARAM = 4'h4, PH_EXTRA = 4'h8
  } byte_phase_t;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] param;
  } cmd_t;

  typedef struct packed {
    logic sda_cap;
    logic tog;
  } link_t;

endpackage : bridge_host_pkg

// ---- tb/host_master_model.sv ----
// host master model that drives the serial bus for the bench
`timescale 1ns/100ps
module host_master_model (
  // link timebase
  input wire logic tick,
  // serial bus
  output logic scl,
  output logic sda_low,
  input wire logic sda_wire
);
  // ----
  // bit and byte level
  // ----
  int half = 16;

  // bus idle: clock stands high and data is released between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic waitq(input int n);
    repeat (n) @(posedge tick);
  endtask : waitq

  // data moves only mid low phase, so it never races the clock rise
  task automatic pulse(input logic b, output logic s);
    waitq(half / 2);
    sda_low <= ~b;
    waitq(half / 2);
    scl <= 1'b1;
    waitq(half / 2);
    s = sda_wire;
    waitq(half / 2);
    scl <= 1'b0;
  endtask : pulse

  // start or repeated start; leaves the clock low
  task automatic start();
    waitq(half / 2);
    sda_low <= 1'b0;
    waitq(half / 2);
    scl <= 1'b1;
    waitq(half);
    sda_low <= 1'b1;
    waitq(half);
    scl <= 1'b0;
  endtask : start

  task automatic stop();
    waitq(half / 2);
    sda_low <= 1'b1;
    waitq(half / 2);
    scl <= 1'b1;
    waitq(half);
    sda_low <= 1'b0;
    waitq(half);
  endtask : stop

  // ack is the wire level seen in the ninth pulse
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) pulse(b[i], s);
    pulse(1'b1, ack);
  endtask : wbyte

  // the last wanted byte is left unacknowledged
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) pulse(1'b1, d[i]);
    pulse(~more, s);
  endtask : rbyte
endmodule : host_master_model

// ---- tb/tb_i2c_bridge_host_port.sv ----
// self-checking bench for the bridge host port
`timescale 1ns/100ps
module tb_i2c_bridge_host_port;
  import bridge_host_pkg::*;
  // ----
  // clocks, wiring and reference state
  // ----
  localparam logic [6:0] ADDR = 7'h2A;
  localparam logic [71:0] CODES = 72'hF0E1D2C3B487A59678;
  localparam logic [31:0] PTRS = 32'hF0E1B4C3;
  logic clock = 1'b0;
  logic tick = 1'b0;
  logic rst_b = 1'b0;
  logic busy = 1'b0;
  logic [7:0] rdata = 8'h00;
  logic scl, sda_low, sda_o, sda_oe, cmd_valid, dev_reset;
  wire sda_wire;
  cmd_t cmd;
  logic [7:0] read_ptr;
  logic [7:0] exp_ptr = 8'hF0;
  logic [17:0] ev;
  logic [17:0] evq[$];
  logic [31:0] seed = 32'hFE66CEA7;
  int miscompares = 0;
  int compares = 0;

  initial forever #50 clock = ~clock;
  // link timebase, offset so it never lines up with the system clock
  initial begin
    #13;
    forever #40 tick = ~tick;
  end
  assign sda_wire = ~((sda_oe & ~sda_o) | sda_low); // open drain with pull-up

  i2c_bridge_host_port #(.DEV_ADDR(ADDR)) i2c_bridge_host_port_inst (
    .clock(clock), .rst_b(rst_b), .scl(scl), .sda_i(sda_wire), .sda_o(sda_o), .sda_oe(sda_oe),
    .line_busy_flag(busy), .read_data(rdata), .cmd_valid(cmd_valid), .cmd(cmd),
    .dev_reset(dev_reset), .read_ptr(read_ptr));
  host_master_model host_master_model_inst (
    .tick(tick), .scl(scl), .sda_low(sda_low), .sda_wire(sda_wire));

  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs

  task automatic sys(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : sys

  task automatic report(input logic [16:0] got, input logic [16:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : report

  task automatic check_bit(input logic got, input logic exp);
    report({16'h0000, got}, {16'h0000, exp});
  endtask : check_bit

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    report({9'h000, got}, {9'h000, exp});
  endtask : check_byte

  task automatic check_cmd(input logic [16:0] got, input logic [16:0] exp);
    report(got, exp);
  endtask : check_cmd

  task automatic complete_run();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // each accepted command must match the oldest expected one;
  // looked at mid-cycle so the registered pulse has settled
  always @(negedge clock) begin
    if (cmd_valid === 1'b1) begin
      if (evq.size() == 0) begin
        check_cmd({dev_reset, cmd}, 17'h1FFFF);
      end else begin
        ev = evq.pop_front();
        check_cmd({dev_reset, cmd.code, ev[17] ? cmd.param : 8'h00}, ev[16:0]);
      end
    end
  end

  // write transfer with reference acks; a refusal ends it early
  task automatic wtxn(input int n, input logic [31:0] q, input logic rs);
    logic [7:0] b, code;
    logic ack, ok;
    int st;
    st = 0;
    code = 8'h00;
    host_master_model_inst.start();
    for (int i = 0; i < n; i++) begin
      b = q[31 - 8 * i -: 8];
      case (st)
        0: ok = (b == {ADDR, 1'b0});
        1: ok = (b inside {8'hF0, 8'hE1, 8'hD2, 8'hC3, 8'hB4, 8'h87, 8'hA5, 8'h96, 8'h78})
            && (!busy || b inside {8'hF0, 8'hE1});
        2: ok = (code != 8'hE1) || (b inside {8'hF0, 8'hE1, 8'hB4, 8'hC3});
        default: ok = 1'b0;
      endcase
      if (ok && st == 1) code = b;
      // the pointer command only moves the pointer; nothing reaches the engine
      if (ok && st == 2 && code == 8'hE1) exp_ptr = b;
      if (ok && code != 8'hE1 &&
          (st == 2 || (st == 1 && b inside {8'hF0, 8'hB4, 8'h96}))) begin
        evq.push_back({st == 2, code == 8'hF0, code,
          st == 2 ? (code == 8'h78 ? (b & 8'h80) : b) : 8'h00});
        if (code == 8'hF0) exp_ptr = 8'hF0;
      end
      if (st == 1 && b inside {8'hF0, 8'hB4, 8'h96}) st = 3;
      else if (st < 2 || code != 8'hC3) st = st + 1;
      host_master_model_inst.wbyte(b, ack);
      check_bit(ack, ~ok);
      if (!ok) break;
    end
    if (!rs) host_master_model_inst.stop();
    check_byte(read_ptr, exp_ptr);
    check_byte(8'(evq.size()), 8'h00);
  endtask : wtxn

  // point at a register, re-address with repeated start, read n bytes
  task automatic rtxn(input int n, input logic [7:0] ptr);
    logic [7:0] d;
    logic ack;
    wtxn(3, {ADDR, 1'b0, 8'hE1, ptr, 8'h00}, 1'b1);
    sys(1);
    rdata = xs();
    host_master_model_inst.start();
    host_master_model_inst.wbyte({ADDR, 1'b1}, ack);
    check_bit(ack, 1'b0);
    for (int i = 0; i < n; i++) begin
      host_master_model_inst.rbyte(i < n - 1, d);
      check_byte(d, rdata);
    end
    host_master_model_inst.stop();
    check_bit(sda_oe, 1'b0);
  endtask : rtxn

  // ----
  // main sequence
  // ----
  initial begin
    logic [7:0] c, p;
    logic a;
    sys(5);
    rst_b = 1'b1;
    sys(5);
    check_byte(read_ptr, 8'hF0);
    // every code, idle engine then busy engine, with one surplus byte unless C3 or refused at the code
    for (int b = 0; b < 2; b++) begin
      for (int k = 0; k < 9; k++) begin
        sys(1);
        busy = b[0];
        c = CODES[71 - 8 * k -: 8];
        p = (c == 8'hE1) ? PTRS[8 * (xs() % 4) +: 8] : xs();
        wtxn(4, {ADDR, 1'b0, c, p, xs()}, 1'b0);
      end
    end
    sys(1);
    busy = 1'b0;
    wtxn(2, {ADDR ^ 7'h01, 1'b0, 8'hF0, 16'h0000}, 1'b0);
    wtxn(3, {ADDR, 1'b0, 8'h55, 16'h0000}, 1'b0);
    wtxn(3, {ADDR, 1'b0, 8'hE1, 8'hE5, 8'h00}, 1'b0);
    wtxn(2, {ADDR, 1'b0, 8'hC3, 16'h0000}, 1'b0);
    rtxn(3, 8'hC3);
    // standard rate: longer clock phases
    host_master_model_inst.half = 62;
    wtxn(4, {ADDR, 1'b0, 8'hC3, xs(), xs()}, 1'b0);
    rtxn(2, 8'hB4);
    host_master_model_inst.half = 16;
    // reset in mid-transfer must drop the partial command
    host_master_model_inst.start();
    host_master_model_inst.wbyte({ADDR, 1'b0}, a);
    check_bit(a, 1'b0);
    sys(1);
    rst_b = 1'b0;
    exp_ptr = 8'hF0;
    sys(2);
    check_bit(sda_oe | cmd_valid | dev_reset, 1'b0);
    check_byte(read_ptr, 8'hF0);
    host_master_model_inst.stop();
    sys(1);
    rst_b = 1'b1;
    sys(5);
    wtxn(3, {ADDR, 1'b0, 8'h87, xs(), 8'h00}, 1'b0);
    complete_run();
  end

  // hang guard, well past the expected few milliseconds
  initial begin
    #6000000;
    miscompares++;
    complete_run();
  end
endmodule : tb_i2c_bridge_host_port
